/* File: fpc_pkg.sv */
// package: register map, field layout and decoded setting types
package fpc_pkg;

  // isa i/o ports of the index/data pair
  localparam logic [15:0] IDX_PORT_ADDR = 16'h002e;
  localparam logic [15:0] DAT_PORT_ADDR = 16'h002f;

  // register indexes
  localparam logic [7:0] IDX_FLOPPY_IRQ_DMA_SELECT      = 8'h06;
  localparam logic [7:0] IDX_PARALLEL_PORT_ENABLE_POWER = 8'h07;
  localparam logic [7:0] IDX_PARALLEL_PORT_MODE_FIFO    = 8'h08;

  // reset values
  localparam logic [7:0] RST_FLOPPY_IRQ_DMA_SELECT      = 8'ha6;
  localparam logic [7:0] RST_PARALLEL_PORT_ENABLE_POWER = 8'hf8;
  localparam logic [7:0] RST_PARALLEL_PORT_MODE_FIFO    = 8'h00;

  // writable bit masks; other bits read back their fixed value
  localparam logic [7:0] WMASK_FLOPPY = 8'h7f;
  localparam logic [7:0] FIXED_FLOPPY = 8'h80;
  localparam logic [7:0] WMASK_PPEN   = 8'h07;
  localparam logic [7:0] FIXED_PPEN   = 8'hf8;
  localparam logic [7:0] WMASK_PMODE  = 8'hff;

  // field positions
  localparam int IRQ_LSB    = 0;
  localparam int DMA_LSB    = 4;
  localparam int DMA_OFF    = 6;
  localparam int PPEN_BIT   = 0;
  localparam int APM_BIT    = 1;
  localparam int LEAK_BIT   = 2;
  localparam int MODE_LSB   = 0;
  localparam int THR_LSB    = 3;
  localparam int ZWS_BIT    = 7;

  // irq codes
  localparam logic [3:0] IRQ_NONE = 4'h0;

  // parallel port modes
  localparam logic [2:0] MODE_ECP_CODE = 3'h4;
  localparam logic [2:0] MODE_RSV5     = 3'h5;
  localparam logic [2:0] MODE_RSV7     = 3'h7;

  typedef enum logic [2:0] {
    FPC_MODE_STANDARD,
    FPC_MODE_BIDIR,
    FPC_MODE_EPP17,
    FPC_MODE_EPP19,
    FPC_MODE_ECP,
    FPC_MODE_RESERVED
  } fpc_mode_e;

  // isa i/o cycle as seen after the pin synchronisers
  typedef struct packed {
    logic [15:0] addr;
    logic        ior;
    logic        iow;
    logic [7:0]  data;
  } fpc_isa_s;

  // decoded floppy resource settings
  typedef struct packed {
    logic [15:0] irq_onehot;
    logic        irq_reserved;
    logic        dma_valid;
    logic [1:0]  dma_chan;
  } fpc_floppy_s;

  // decoded parallel port settings
  typedef struct packed {
    logic      decode_en;
    logic      power_down;
    logic      apm_en;
    logic      pins_isolated;
    fpc_mode_e mode;
    logic [4:0] fifo_threshold;
    logic      zero_wait_state_enable;
  } fpc_pport_s;

endpackage : fpc_pkg

/* File: fpc_irq_decode.sv */
// irq code to one-hot line decoder
`timescale 1ns/1ps
module fpc_irq_decode (
  input  wire logic [3:0]  code,
  output logic      [15:0] line_onehot,
  output logic             reserved
);

  // none and reserved codes drive no line
  always_comb begin
    line_onehot = 16'h0000;
    reserved    = 1'b0;
    case (code)
      4'h1, 4'h2, 4'h8, 4'hc, 4'hd: reserved = 1'b1;
      fpc_pkg::IRQ_NONE: line_onehot = 16'h0000;
      default: line_onehot = 16'h0001 << code;
    endcase
  end

endmodule : fpc_irq_decode

/* File: fpc_config_regs.sv */
// configuration registers for floppy resources and parallel port setup
// Contract
// - floppy register bits 3:0 pick irq 3-7, 9-11, 14, 15 or none; 1,2,8,c,d are reserved.
// - floppy register bits 6:4 pick dma channel 0-3; bit 6 set means no dma channel.
// - port enable bit 0 clear removes the port from decode and powers it down.
// - port enable bit 1 turns automatic power management on or off.
// - leakage bit 2 set isolates the port pins during power down; clear keeps them normal.
// - port enable bits 7:3 always read ones.
// - mode bits 2:0 select standard, bidirectional, epp 1.7, epp 1.9 or ecp; 5, 6 and 7 reserved.
// - mode bits 6:3 set the fifo threshold to the field plus one.
// - the host writes the index at port 2e, then reads or writes data at port 2f.
// - every register takes its reset value while the isa reset is high.
`timescale 1ns/1ps
module fpc_config_regs (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic [15:0]         isa_addr,
  input  wire logic                isa_ior_n,
  input  wire logic                isa_iow_n,
  input  wire logic [7:0]          isa_data_in,
  input  wire logic                pport_cycle,
  output logic      [7:0]          isa_data_out,
  output logic                     isa_data_oe,
  output logic                     zero_wait_state_n,
  output fpc_pkg::fpc_floppy_s     floppy_cfg,
  output fpc_pkg::fpc_pport_s      pport_cfg
);

  // whole module state
  typedef struct packed {
    fpc_pkg::fpc_isa_s   s1;
    fpc_pkg::fpc_isa_s   s2;
    logic                pp1;
    logic                pp2;
    logic                iow_prev;
    logic [7:0]          index;
    logic [7:0]          floppy;
    logic [7:0]          ppen;
    logic [7:0]          pmode;
    logic [7:0]          dout;
    logic                doe;
    logic                zws_n;
    fpc_pkg::fpc_floppy_s fcfg;
    fpc_pkg::fpc_pport_s  pcfg;
  } fpc_state_s;

  fpc_state_s       st_q;
  fpc_state_s       st_d;
  fpc_pkg::fpc_isa_s isa_raw;
  logic [15:0]      irq_onehot;
  logic             irq_reserved;

  // decode mode field to enum
  function automatic fpc_pkg::fpc_mode_e mode_of(input logic [2:0] f);
    case (f)
      3'h0:    mode_of = fpc_pkg::FPC_MODE_STANDARD;
      3'h1:    mode_of = fpc_pkg::FPC_MODE_BIDIR;
      3'h2:    mode_of = fpc_pkg::FPC_MODE_EPP17;
      3'h3:    mode_of = fpc_pkg::FPC_MODE_EPP19;
      fpc_pkg::MODE_ECP_CODE: mode_of = fpc_pkg::FPC_MODE_ECP;
      default: mode_of = fpc_pkg::FPC_MODE_RESERVED;
    endcase
  endfunction : mode_of

  // merge write data through a mask
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr,
                                       input logic [7:0] msk, input logic [7:0] fix);
    merge = (wr & msk) | (old & ~msk & ~fix) | fix;
  endfunction : merge

  assign isa_raw = '{addr: isa_addr, ior: ~isa_ior_n, iow: ~isa_iow_n, data: isa_data_in};

  fpc_irq_decode u_irq (
    .code        (st_q.floppy[fpc_pkg::IRQ_LSB +: 4]),
    .line_onehot (irq_onehot),
    .reserved    (irq_reserved)
  );

  // next state
  always_comb begin
    logic wr_edge;
    logic pd;
    wr_edge = 1'b0;
    pd      = 1'b0;
    st_d    = st_q;
    st_d.s1 = isa_raw;
    st_d.s2 = st_q.s1;
    st_d.pp1 = pport_cycle;
    st_d.pp2 = st_q.pp1;
    st_d.iow_prev = st_q.s2.iow;
    wr_edge = st_q.s2.iow && !st_q.iow_prev;
    if (wr_edge && st_q.s2.addr == fpc_pkg::IDX_PORT_ADDR) begin
      st_d.index = st_q.s2.data;
    end
    if (wr_edge && st_q.s2.addr == fpc_pkg::DAT_PORT_ADDR) begin
      case (st_q.index)
        fpc_pkg::IDX_FLOPPY_IRQ_DMA_SELECT: st_d.floppy = merge(st_q.floppy, st_q.s2.data,
            fpc_pkg::WMASK_FLOPPY, fpc_pkg::FIXED_FLOPPY);
        fpc_pkg::IDX_PARALLEL_PORT_ENABLE_POWER: st_d.ppen = merge(st_q.ppen, st_q.s2.data,
            fpc_pkg::WMASK_PPEN, fpc_pkg::FIXED_PPEN);
        fpc_pkg::IDX_PARALLEL_PORT_MODE_FIFO: st_d.pmode = merge(st_q.pmode, st_q.s2.data,
            fpc_pkg::WMASK_PMODE, 8'h00);
        default: st_d.index = st_q.index;
      endcase
    end
    // read path; fixed ones held in storage
    st_d.doe  = 1'b0;
    st_d.dout = 8'h00;
    if (st_q.s2.ior && st_q.s2.addr == fpc_pkg::IDX_PORT_ADDR) begin
      st_d.doe  = 1'b1;
      st_d.dout = st_q.index;
    end else if (st_q.s2.ior && st_q.s2.addr == fpc_pkg::DAT_PORT_ADDR) begin
      st_d.doe = 1'b1;
      case (st_q.index)
        fpc_pkg::IDX_FLOPPY_IRQ_DMA_SELECT:      st_d.dout = st_q.floppy | fpc_pkg::FIXED_FLOPPY;
        fpc_pkg::IDX_PARALLEL_PORT_ENABLE_POWER: st_d.dout = st_q.ppen | fpc_pkg::FIXED_PPEN;
        fpc_pkg::IDX_PARALLEL_PORT_MODE_FIFO:    st_d.dout = st_q.pmode;
        default:                                 st_d.dout = 8'hff;
      endcase
    end
    st_d.fcfg.irq_onehot   = irq_onehot;
    st_d.fcfg.irq_reserved = irq_reserved;
    st_d.fcfg.dma_valid = !st_q.floppy[fpc_pkg::DMA_OFF];
    st_d.fcfg.dma_chan  = st_q.floppy[fpc_pkg::DMA_LSB +: 2];
    pd = !st_q.ppen[fpc_pkg::PPEN_BIT];
    st_d.pcfg.decode_en  = !pd;
    st_d.pcfg.power_down = pd;
    st_d.pcfg.apm_en = st_q.ppen[fpc_pkg::APM_BIT];
    st_d.pcfg.pins_isolated = pd && st_q.ppen[fpc_pkg::LEAK_BIT];
    st_d.pcfg.mode = mode_of(st_q.pmode[fpc_pkg::MODE_LSB +: 3]);
    st_d.pcfg.fifo_threshold = {1'b0, st_q.pmode[fpc_pkg::THR_LSB +: 4]} + 5'h01;
    // zero wait state on enabled port cycles
    st_d.pcfg.zero_wait_state_enable = st_q.pmode[fpc_pkg::ZWS_BIT];
    st_d.zws_n = !(st_q.pmode[fpc_pkg::ZWS_BIT] && st_q.pp2 && !pd);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q        <= '0;
      st_q.floppy <= fpc_pkg::RST_FLOPPY_IRQ_DMA_SELECT;
      st_q.ppen   <= fpc_pkg::RST_PARALLEL_PORT_ENABLE_POWER;
      st_q.pmode  <= fpc_pkg::RST_PARALLEL_PORT_MODE_FIFO;
      st_q.zws_n  <= 1'b1;
      st_q.pcfg.decode_en  <= 1'b0;
      st_q.pcfg.power_down <= 1'b1;
      st_q.pcfg.fifo_threshold <= 5'h01;
    end else begin
      st_q <= st_d;
    end
  end

  assign isa_data_out      = st_q.dout;
  assign isa_data_oe       = st_q.doe;
  assign zero_wait_state_n = st_q.zws_n;
  assign floppy_cfg        = st_q.fcfg;
  assign pport_cfg         = st_q.pcfg;

  a_floppy_bit7: assert property (@(posedge clk_sys) disable iff (rst)
    st_q.doe && $past(st_q.s2.addr) == fpc_pkg::DAT_PORT_ADDR
    && $past(st_q.index) == fpc_pkg::IDX_FLOPPY_IRQ_DMA_SELECT |-> st_q.dout[7])
    else $error("floppy bit 7 read as zero");
  a_ppen_ones: assert property (@(posedge clk_sys) disable iff (rst)
    st_q.doe && $past(st_q.s2.addr) == fpc_pkg::DAT_PORT_ADDR
    && $past(st_q.index) == fpc_pkg::IDX_PARALLEL_PORT_ENABLE_POWER
    |-> st_q.dout[7:3] == 5'h1f)
    else $error("enable reserved bits not ones");
  a_pport_decode: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 pport_cfg.decode_en == $past(st_q.ppen[fpc_pkg::PPEN_BIT])
    && pport_cfg.power_down != pport_cfg.decode_en)
    else $error("decode enable mismatch");
  a_apm_follow: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 pport_cfg.apm_en == $past(st_q.ppen[fpc_pkg::APM_BIT]))
    else $error("apm enable mismatch");
  // at most one irq line, none for reserved codes
  a_irq_onehot: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot0(floppy_cfg.irq_onehot) && !(floppy_cfg.irq_reserved && |floppy_cfg.irq_onehot))
    else $error("irq line decode wrong");
  a_leak_iso: assert property (@(posedge clk_sys) disable iff (rst)
    pport_cfg.pins_isolated |-> pport_cfg.power_down)
    else $error("pins isolated while powered");
  a_fifo_thr: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 pport_cfg.fifo_threshold == {1'b0, $past(st_q.pmode[fpc_pkg::THR_LSB +: 4])} + 5'h01)
    else $error("fifo threshold wrong");
  // dma off when bit 6 set
  a_dma_off: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 $past(st_q.floppy[fpc_pkg::DMA_OFF]) |-> !floppy_cfg.dma_valid)
    else $error("dma valid with bit 6 set");
  a_zws_gate: assert property (@(posedge clk_sys) disable iff (rst)
    !zero_wait_state_n |-> $past(st_q.pmode[fpc_pkg::ZWS_BIT]))
    else $error("zero wait without enable");
  // reserved bits never stored as zero
  a_fixed_store: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.floppy & fpc_pkg::FIXED_FLOPPY) == fpc_pkg::FIXED_FLOPPY
    && (st_q.ppen & fpc_pkg::FIXED_PPEN) == fpc_pkg::FIXED_PPEN)
    else $error("reserved bits lost");
  // data write at the mode/fifo index lands in the pmode register
  sequence s_pmode_write;
    st_q.s2.iow && !st_q.iow_prev && st_q.s2.addr == fpc_pkg::DAT_PORT_ADDR
    && st_q.index == fpc_pkg::IDX_PARALLEL_PORT_MODE_FIFO;
  endsequence
  a_data_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_pmode_write |=> st_q.pmode == $past(st_q.s2.data))
    else $error("data port write lost");
  a_reset_vals: assert property (@(posedge clk_sys)
    rst |=> st_q.floppy == fpc_pkg::RST_FLOPPY_IRQ_DMA_SELECT
    && st_q.ppen == fpc_pkg::RST_PARALLEL_PORT_ENABLE_POWER
    && st_q.pmode == fpc_pkg::RST_PARALLEL_PORT_MODE_FIFO)
    else $error("reset value wrong");

endmodule : fpc_config_regs

/* File: fpc_isa_host.sv */
// isa host model running index/data port cycles
`timescale 1ns/1ps
module fpc_isa_host (
  input  wire logic        clk_sys,
  output logic      [15:0] isa_addr,
  output logic             isa_ior_n,
  output logic             isa_iow_n,
  output logic      [7:0]  host_data,
  input  wire logic [7:0]  isa_data_out,
  input  wire logic        isa_data_oe
);
  initial begin
    isa_addr  = 16'h0000;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
    host_data = 8'h00;
  end

  // one strobe, six cycles low; released lines show inverted values
  task automatic cyc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [8:0] q);
    @(posedge clk_sys);
    isa_addr  <= a;
    host_data <= d;
    isa_iow_n <= ~wr;
    isa_ior_n <= wr;
    repeat (6) @(posedge clk_sys);
    q = {isa_data_oe, isa_data_out};
    isa_iow_n <= 1'b1;
    isa_ior_n <= 1'b1;
    isa_addr  <= ~a;
    host_data <= ~d;
    repeat (5) @(posedge clk_sys);
  endtask : cyc

  // index port first, then data port
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [8:0] q);
    cyc(1'b1, fpc_pkg::IDX_PORT_ADDR, idx, q);
    cyc(wr, fpc_pkg::DAT_PORT_ADDR, d, q);
  endtask : acc
endmodule : fpc_isa_host

/* File: tb_fpc_config_regs.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_fpc_config_regs;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 pport_cycle = 1'b0;
  logic [15:0]          isa_addr;
  logic                 isa_ior_n;
  logic                 isa_iow_n;
  logic [7:0]           host_data;
  logic [7:0]           isa_data_out;
  logic                 isa_data_oe;
  logic                 zero_wait_state_n;
  fpc_pkg::fpc_floppy_s floppy_cfg;
  fpc_pkg::fpc_pport_s  pport_cfg;
  fpc_pkg::fpc_floppy_s ef;
  int                   n_errors = 0;
  int                   n_compared = 0;
  logic [31:0]          rs = 32'h0000004c; // xorshift seed, 76
  logic [8:0]           q;
  logic [7:0]           d6;
  logic [7:0]           d7;
  logic [7:0]           d8;
  logic                 pc;
  wire  [7:0]           bus = isa_data_oe ? isa_data_out : host_data;

  always #2 clk_sys = ~clk_sys;

  fpc_isa_host host (.clk_sys(clk_sys), .isa_addr(isa_addr), .isa_ior_n(isa_ior_n),
    .isa_iow_n(isa_iow_n), .host_data(host_data), .isa_data_out(isa_data_out),
    .isa_data_oe(isa_data_oe));

  fpc_config_regs uut (.clk_sys(clk_sys), .rst(rst), .isa_addr(isa_addr),
    .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n), .isa_data_in(bus),
    .pport_cycle(pport_cycle), .isa_data_out(isa_data_out), .isa_data_oe(isa_data_oe),
    .zero_wait_state_n(zero_wait_state_n), .floppy_cfg(floppy_cfg), .pport_cfg(pport_cfg));

  // xorshift step
  function automatic logic [31:0] rnd(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd

  // expected floppy decode
  function automatic fpc_pkg::fpc_floppy_s exp_fl(input logic [7:0] d);
    fpc_pkg::fpc_floppy_s e;
    e = '0;
    e.irq_reserved = d[3:0] inside {4'h1, 4'h2, 4'h8, 4'hc, 4'hd};
    if (d[3:0] != 4'h0 && !e.irq_reserved) e.irq_onehot[d[3:0]] = 1'b1;
    e.dma_valid = ~d[6];
    e.dma_chan = d[5:4];
    return e;
  endfunction : exp_fl

  // expected parallel port decode
  function automatic fpc_pkg::fpc_pport_s exp_pp(input logic [7:0] a, input logic [7:0] b);
    fpc_pkg::fpc_pport_s e;
    e.decode_en = a[0];
    e.power_down = ~a[0];
    e.apm_en = a[1];
    e.pins_isolated = ~a[0] & a[2];
    e.mode = (b[2:0] > 3'h4) ? fpc_pkg::FPC_MODE_RESERVED : fpc_pkg::fpc_mode_e'(b[2:0]);
    e.fifo_threshold = {1'b0, b[6:3]} + 5'h01;
    e.zero_wait_state_enable = b[7];
    return e;
  endfunction : exp_pp

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // read all three registers and the decoded settings
  task automatic check_all(input logic [7:0] a6, input logic [7:0] a7, input logic [7:0] a8);
    host.acc(1'b0, fpc_pkg::IDX_FLOPPY_IRQ_DMA_SELECT, 8'h00, q);
    chk("floppy_reg", 32'(q), {23'h0, 1'b1, a6 | 8'h80});
    host.acc(1'b0, fpc_pkg::IDX_PARALLEL_PORT_ENABLE_POWER, 8'h00, q);
    chk("ppen_reg", 32'(q), {23'h0, 1'b1, a7 | 8'hf8});
    host.acc(1'b0, fpc_pkg::IDX_PARALLEL_PORT_MODE_FIFO, 8'h00, q);
    chk("pmode_reg", 32'(q), {23'h0, 1'b1, a8});
    ef = exp_fl(a6);
    chk("irq", 32'(floppy_cfg[19:3]), 32'(ef[19:3]));
    chk("dma_valid", 32'(floppy_cfg.dma_valid), 32'(ef.dma_valid));
    if (ef.dma_valid) chk("dma_chan", 32'(floppy_cfg.dma_chan), 32'(a6[5:4]));
    chk("pport_cfg", 32'(pport_cfg), 32'(exp_pp(a7, a8)));
    chk("zws_n", {31'h0, zero_wait_state_n}, {31'h0, ~(a8[7] & a7[0] & pc)});
  endtask : check_all

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end

  // main sequence
  initial begin
    pc = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    check_all(8'ha6, 8'hf8, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      rs = rnd(rs);
      d6 = {rs[7:4], 4'(i)};
      d7 = rs[15:8] | {7'h0, i[1]};
      d8 = {rs[23] | i[1], rs[22:19], 3'(i)};
      pc = rs[24] | i[1];
      pport_cycle <= pc;
      host.acc(1'b1, fpc_pkg::IDX_FLOPPY_IRQ_DMA_SELECT, d6, q);
      host.acc(1'b1, fpc_pkg::IDX_PARALLEL_PORT_ENABLE_POWER, d7, q);
      host.acc(1'b1, fpc_pkg::IDX_PARALLEL_PORT_MODE_FIFO, d8, q);
      check_all(d6, d7, d8);
    end
    $display("test random writes done");
    host.acc(1'b1, 8'h40, 8'h00, q);
    host.acc(1'b0, 8'h40, 8'h00, q);
    chk("unmapped", 32'(q), 32'h1ff);
    host.cyc(1'b0, fpc_pkg::IDX_PORT_ADDR, 8'h00, q);
    chk("index", 32'(q), 32'h140);
    check_all(d6, d7, d8);
    $display("test unmapped index done");
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    check_all(8'ha6, 8'hf8, 8'h00);
    $display("test second reset done");
    test_done();
  end
endmodule : tb_fpc_config_regs
